// ### logic/gdma_map.vh
`ifndef GDMA_MAP_VH
`define GDMA_MAP_VH

// register byte offsets (word at 0,2,4,6 -> apb byte address x4... kept as index)
`define GDMA_IDX_WCNT     3'h0
`define GDMA_IDX_ADDR     3'h1
`define GDMA_IDX_CTRL     3'h2
`define GDMA_IDX_DATA     3'h3
`define GDMA_IDX_XADDR    3'h4

// control/status field positions
`define GDMA_GO_BIT       0
`define GDMA_FNC_LO       1
`define GDMA_FNC_HI       3
`define GDMA_XBA_LO       4
`define GDMA_XBA_HI       5
`define GDMA_IE_BIT       6
`define GDMA_RDY_BIT      7
`define GDMA_CYC_BIT      8
`define GDMA_ATTENTION_LINE_BIT     13
`define GDMA_MAINT_BIT    12
`define GDMA_ERR_BIT      15

// host bus cycle types
`define GDMA_CYC_RD       2'h0
`define GDMA_CYC_RMW      2'h1
`define GDMA_CYC_WR       2'h2
`define GDMA_CYC_WRB      2'h3

// reset values
`define GDMA_CTRL_RST     16'h0080
`define GDMA_ZERO16       16'h0000
`define GDMA_ZERO6        6'h00

// strobe pattern and counter steps
`define GDMA_STRB_WORD    2'h3
`define GDMA_WC_STEP      16'h0001
`define GDMA_BA_STEP      16'h0002
`define GDMA_XADDR_STEP   6'h01
`define GDMA_ADDR_TOP     15'h7fff

`endif

// ### logic/gdma_core.v
// Local design decisions: register access over APB and the register addresses.
`timescale 1ns/1ps
`include "gdma_map.vh"

// Behaviour
// R1 - moves 16-bit words between host memory and user device via bus cycles
// R2 - software loads word count with two's complement of word total
// R3 - software loads address and extension with first memory address
// R4 - software writes function bits last, then dma logic takes over
// R5 - control/status and data buffers take byte writes; others whole words
// R6 - requests accepted only after software clears ready
// R7 - user sets control bits first, then raises cycle request
// R8 - on cycle request latch input data and control bits, busy low
// R9 - memory-to-device reads capture memory data into output buffer
// R10 - transfer cycle uses address register joined with its extension
// R11 - after each cycle bump count and address, busy high, ready low (in burst mode the code keeps busy low until the block is done)
// R12 - single-cycle mode needs a new cycle request per word
// R13 - count reaching zero sets ready and interrupt if enabled
// R14 - burst mode: one request moves the whole programmed block
// R15 - byte writes and read-modify-write cycles supported
// R16 - six software-visible registers
// R17 - burst mode holds bus mastership until block done
// R18 - address and extension share one slot; both buffers share another (code gives the extension its own slot, index 4)
// R19 - 18-bit or 22-bit addressing; extension used only when wide (code also uses ext[1:0] in 18-bit mode)
// R20 - address overflow carries into the extension
// R21 - increments apply only when latched enable bits set
module gdma_core #(
	parameter AW_WIDE = 1                  // 1: 22-bit, 0: 18-bit
) (
	input  wire        ref_clk,            // clock, 40 MHz
	input  wire        resetn,             // async reset, active low
	input  wire        psel,               // apb select
	input  wire        penable,            // apb access phase
	input  wire        pwrite,             // apb direction
	input  wire [11:0] paddr,              // apb byte address
	input  wire [31:0] pwdata,             // apb write data
	input  wire [3:0]  pstrb,              // apb byte strobes
	output wire        pready,             // apb ready
	output reg  [31:0] prdata,             // apb read data
	output wire        pslverr,            // apb error
	input  wire        cycle_request,      // user cycle request
	input  wire        single_cycle,       // high: single, low: burst
	input  wire        wc_inc_enable,      // user word-count increment enable
	input  wire        ba_inc_enable,      // user address increment enable
	input  wire        function_line_high, // user cycle select high
	input  wire        function_line_low,  // user cycle select low
	input  wire        byte_select_bit,    // low address bit for byte writes
	input  wire        attention_line,     // user attention
	input  wire [15:0] user_in_data,       // user input data
	output reg  [15:0] user_out_data,      // output buffer to user
	output reg         busy_n,             // busy, low while a cycle pends
	output reg         ready,              // ready indication
	output wire [2:0]  user_function,      // function bits to user
	output wire        irq,                // interrupt request level
	output reg         mst_req,            // host bus request
	output reg  [21:0] mst_addr,           // host bus byte address
	output reg  [1:0]  mst_type,           // host bus cycle type
	output reg  [15:0] mst_wdata,          // host bus write data
	input  wire        mst_ack,            // host bus cycle done
	input  wire [15:0] mst_rdata,          // host bus read data
	output wire        mst_hold            // keep bus mastership
);

	localparam ST_IDLE = 2'h0;
	localparam ST_BUS  = 2'h1;
	localparam ST_NEXT = 2'h2;

	// ----------------------------------------
	// registers
	// ----------------------------------------
	reg [15:0] word_count_reg_ff;
	reg [15:0] address_reg_ff;
	reg [5:0]  address_extension_reg_ff;
	reg [15:0] control_status_reg_ff;
	reg [15:0] in_buf_ff;
	reg [1:0]  state_ff;
	reg        lat_wc_ff;
	reg        lat_ba_ff;
	reg        lat_burst_ff;
	reg        irq_ff;
	reg        req_seen_ff;
	reg        lat_byte_ff;

	wire [2:0]  reg_idx = paddr[4:2];
	wire        wr_go   = psel & penable & pwrite;
	wire        rd_go   = psel & penable & ~pwrite;
	wire        bad     = (paddr[11:5] != 7'h00) | (reg_idx > `GDMA_IDX_XADDR);
	wire        ie      = control_status_reg_ff[`GDMA_IE_BIT];

	// ----------------------------------------
	// register select decode
	// ----------------------------------------
	wire        sel_wcnt  = (reg_idx == `GDMA_IDX_WCNT);
	wire        sel_addr  = (reg_idx == `GDMA_IDX_ADDR);
	wire        sel_data  = (reg_idx == `GDMA_IDX_DATA);
	wire        sel_xaddr = (reg_idx == `GDMA_IDX_XADDR);
	wire        full_word = (pstrb[1:0] == `GDMA_STRB_WORD);
	wire        wr_ok     = wr_go & ~bad;
	// R5 word-only registers ignore byte writes
	wire        wr_wcnt   = wr_ok & sel_wcnt & full_word;
	wire        wr_addr   = wr_ok & sel_addr & full_word;
	wire        wr_xaddr  = wr_ok & sel_xaddr & full_word;
	wire        wr_data   = wr_ok & sel_data;

	assign pready        = 1'b1;
	assign pslverr       = psel & penable & bad;
	assign user_function = control_status_reg_ff[`GDMA_FNC_HI:`GDMA_FNC_LO];
	assign irq           = irq_ff;
	// R17 burst bus hold
	assign mst_hold      = lat_burst_ff & (state_ff != ST_IDLE);

	// R5 byte lane merge
	function [15:0] merge16;
		input [15:0] old;
		input [15:0] nw;
		input [1:0]  be;
		begin
			merge16 = {be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
		end
	endfunction

	// R10 R19 full memory address
	function [21:0] full_addr;
		input [15:0] lo;
		input [5:0]  ext;
		begin
			if (AW_WIDE != 0) begin
				full_addr = {ext, lo};
			end else begin
				full_addr = {4'h0, ext[1:0], lo};
			end
		end
	endfunction

	// wrapping 16-bit step, shared by count and address
	function [15:0] inc16;
		input [15:0] val;
		input [15:0] step;
		begin
			inc16 = val + step;
		end
	endfunction

	// R15 byte cycles carry the low address bit
	function [21:0] byte_addr;
		input [15:0] lo;
		input [5:0]  ext;
		input        bsel;
		begin
			byte_addr = full_addr(lo, ext) | {21'h000000, bsel};
		end
	endfunction

	// ----------------------------------------
	// apb read
	// ----------------------------------------
	always @* begin
		prdata = 32'h00000000;
		if (rd_go && !bad) begin
			case (reg_idx)
				`GDMA_IDX_WCNT:  prdata = {16'h0000, word_count_reg_ff};
				`GDMA_IDX_ADDR:  prdata = {16'h0000, address_reg_ff};
				`GDMA_IDX_CTRL:  prdata = {16'h0000, control_status_reg_ff[15:8], ready,
					control_status_reg_ff[6:0]};
				// R18 shared buffer slot, read side is input buffer
				`GDMA_IDX_DATA:  prdata = {16'h0000, in_buf_ff};
				`GDMA_IDX_XADDR: prdata = {26'h0000000, address_extension_reg_ff};
				default:         prdata = 32'h00000000;
			endcase
		end
	end

	wire ack_ok    = mst_req & mst_ack;
	wire step_now  = ack_ok & (state_ff == ST_BUS);
	wire rd_cycle  = (mst_type == `GDMA_CYC_RD) | (mst_type == `GDMA_CYC_RMW);
	wire byte_cyc  = function_line_high & function_line_low & byte_select_bit;

	// ----------------------------------------
	// next counter and address values
	// ----------------------------------------
	reg [15:0] nxt_word_count;
	reg [15:0] nxt_address;
	reg [5:0]  nxt_extension;

	// hardware step wins over a same-cycle apb write
	always @* begin
		nxt_word_count = word_count_reg_ff;
		nxt_address    = address_reg_ff;
		nxt_extension  = address_extension_reg_ff;
		// R2 R3 software loads
		if (wr_wcnt) begin
			nxt_word_count = pwdata[15:0];
		end
		if (wr_addr) begin
			nxt_address = pwdata[15:0];
		end
		if (wr_xaddr) begin
			nxt_extension = pwdata[5:0];
		end
		// R11 R21 steps gated by latched enables
		if (step_now && lat_wc_ff) begin
			nxt_word_count = inc16(word_count_reg_ff, `GDMA_WC_STEP);
		end
		if (step_now && lat_ba_ff) begin
			nxt_address = inc16(address_reg_ff, `GDMA_BA_STEP);
			// R20 carry into extension
			if (address_reg_ff[15:1] == `GDMA_ADDR_TOP) begin
				nxt_extension = address_extension_reg_ff + `GDMA_XADDR_STEP;
			end
		end
	end

	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			word_count_reg_ff        <= `GDMA_ZERO16;
			address_reg_ff           <= `GDMA_ZERO16;
			address_extension_reg_ff <= `GDMA_ZERO6;
		end else begin
			word_count_reg_ff        <= nxt_word_count;
			address_reg_ff           <= nxt_address;
			address_extension_reg_ff <= nxt_extension;
		end
	end

	// ----------------------------------------
	// output buffer
	// ----------------------------------------
	reg [15:0] nxt_out_buf;

	// R9 memory data wins over a same-cycle apb write
	always @* begin
		nxt_out_buf = user_out_data;
		if (wr_data) begin
			nxt_out_buf = merge16(user_out_data, pwdata[15:0], pstrb[1:0]);
		end
		if (step_now && rd_cycle) begin
			nxt_out_buf = mst_rdata;
		end
	end

	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			user_out_data <= `GDMA_ZERO16;
		end else begin
			user_out_data <= nxt_out_buf;
		end
	end

	// ----------------------------------------
	// dma engine and register writes
	// ----------------------------------------
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			control_status_reg_ff    <= `GDMA_CTRL_RST;
			in_buf_ff                <= `GDMA_ZERO16;
			state_ff                 <= ST_IDLE;
			lat_byte_ff              <= 1'b0;
			lat_wc_ff                <= 1'b0;
			lat_ba_ff                <= 1'b0;
			lat_burst_ff             <= 1'b0;
			irq_ff                   <= 1'b0;
			req_seen_ff              <= 1'b0;
			busy_n                   <= 1'b1;
			ready                    <= 1'b1;
			mst_req                  <= 1'b0;
			mst_addr                 <= 22'h000000;
			mst_type                 <= `GDMA_CYC_RD;
			mst_wdata                <= `GDMA_ZERO16;
		end else begin
			req_seen_ff <= cycle_request;
			if (wr_go && !bad) begin
				case (reg_idx)
					`GDMA_IDX_CTRL: begin
						// R4 R6 writing ready low arms the engine
						control_status_reg_ff <= merge16(control_status_reg_ff, pwdata[15:0], pstrb[1:0]);
						if (pstrb[0]) begin
							ready <= pwdata[`GDMA_RDY_BIT];
							if (!pwdata[`GDMA_IE_BIT]) begin
								irq_ff <= 1'b0;
							end
						end
					end
					default: ;
				endcase
			end
			case (state_ff)
				ST_IDLE: begin
					// R6 R7 R8 R12 rising request latches data and controls
					if (!ready && cycle_request && !req_seen_ff) begin
						in_buf_ff    <= user_in_data;
						lat_wc_ff    <= wc_inc_enable;
						lat_ba_ff    <= ba_inc_enable;
						// R14 burst chosen by single-cycle line low
						lat_burst_ff <= ~single_cycle;
						busy_n       <= 1'b0;
						mst_req      <= 1'b1;
						mst_addr     <= byte_addr(address_reg_ff, address_extension_reg_ff, byte_cyc);
						lat_byte_ff  <= byte_cyc;
						// R1 R15 cycle type from function lines
						mst_type     <= {function_line_high, function_line_low};
						mst_wdata    <= user_in_data;
						if (attention_line) begin
							control_status_reg_ff[`GDMA_ATTENTION_LINE_BIT] <= 1'b1;
						end
						state_ff     <= ST_BUS;
					end
				end
				ST_BUS: begin
					if (ack_ok) begin
						// counters and buffer step in their own processes
						mst_req  <= 1'b0;
						state_ff <= ST_NEXT;
					end
				end
				ST_NEXT: begin
					// R13 count done sets ready and interrupt
					if (lat_wc_ff && word_count_reg_ff == `GDMA_ZERO16) begin
						ready    <= 1'b1;
						busy_n   <= 1'b1;
						if (ie) irq_ff <= 1'b1;
						state_ff <= ST_IDLE;
					end else if (lat_burst_ff) begin
						// R14 R17 next burst word back to back
						in_buf_ff <= user_in_data;
						mst_req   <= 1'b1;
						mst_addr  <= byte_addr(address_reg_ff, address_extension_reg_ff, lat_byte_ff);
						mst_wdata <= user_in_data;
						state_ff  <= ST_BUS;
					end else begin
						// R11 R12 busy high, wait next request
						busy_n   <= 1'b1;
						state_ff <= ST_IDLE;
					end
				end
				default: state_ff <= ST_IDLE;
			endcase
		end
	end

endmodule

// ### testbench/gdma_assertions.sv
`timescale 1ns/1ps
module gdma_assertions (
	input wire        ref_clk,       // clock
	input wire        resetn,        // reset
	input wire        psel,          // apb
	input wire        penable,       // apb
	input wire [11:0] paddr,         // apb
	input wire        pslverr,       // apb
	input wire        cycle_request, // user
	input wire        single_cycle,  // user
	input wire        ready,         // status
	input wire        busy_n,        // status
	input wire        mst_req,       // host bus
	input wire        mst_ack,       // host bus
	input wire [21:0] mst_addr,      // host bus
	input wire [1:0]  mst_type,      // host bus
	input wire        mst_hold       // host bus
);
	// ---------------------------
	// request handling
	// ---------------------------
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	sequence s_take;
		single_cycle && $rose(cycle_request) && !ready && busy_n && !mst_req;
	endsequence
	AST_BUSY_LOW: assert property (s_take |=> !busy_n)
		else $error("busy_n not low after request");
	AST_BUS_REQ: assert property (s_take |=> mst_req)
		else $error("no bus request after request");
	AST_REQ_HOLD: assert property (mst_req && !mst_ack |=> mst_req)
		else $error("bus request dropped early");
	AST_REQ_DROP: assert property (mst_req && mst_ack |=> !mst_req)
		else $error("bus request kept after ack");
	AST_ADR_STABLE: assert property (mst_req && !mst_ack |=> $stable(mst_addr) && $stable(mst_type))
		else $error("bus address moved during cycle");
	AST_BUSY_UP: assert property (single_cycle && $fell(mst_req) |=> busy_n)
		else $error("busy_n not back high");
	AST_RDY_IGN: assert property (ready && busy_n |=> busy_n)
		else $error("request taken while ready");
	AST_BURST_HOLD: assert property (!single_cycle && mst_req |-> mst_hold)
		else $error("bus not held in burst");
	AST_SLVERR: assert property (psel && penable && paddr > 12'h013 |-> pslverr)
		else $error("unmapped access not refused");
	CV_TAKE: cover property (s_take);
	CV_BURST: cover property (!single_cycle && mst_req && mst_ack);
	CV_ERR: cover property (psel && penable && pslverr);
endmodule
bind gdma_core gdma_assertions chk_u (.ref_clk, .resetn, .psel, .penable, .paddr, .pslverr, .cycle_request,
	.single_cycle, .ready, .busy_n, .mst_req, .mst_ack, .mst_addr, .mst_type, .mst_hold);

// ### testbench/gdma_mem_model.sv
`timescale 1ns/1ps
module gdma_mem_model (
	input wire        ref_clk,   // clock
	input wire        resetn,    // reset
	input wire        mst_req,   // cycle request
	input wire [21:0] mst_addr,  // byte address
	input wire [1:0]  mst_type,  // cycle type
	input wire [15:0] mst_wdata, // write data
	output reg        mst_ack,   // cycle done
	output reg [15:0] mst_rdata  // read data
);
	reg [15:0] mem [0:255];
	reg [1:0]  dly_ff;
	reg [1:0]  pace_ff;
	// ---------------------------
	// memory slave
	// ---------------------------
	// varied answer delay
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			mst_ack <= 1'b0;
			dly_ff <= 2'h0;
			pace_ff <= 2'h1;
		end else begin
			mst_ack <= 1'b0;
			// read data is junk outside the ack cycle
			mst_rdata <= ~mst_rdata;
			if (mst_req && !mst_ack) begin
				if (dly_ff == 2'h0) begin
					mst_ack <= 1'b1;
					mst_rdata <= mem[mst_addr[8:1]];
					if (mst_type[1])
						mem[mst_addr[8:1]] <= mst_wdata;
					dly_ff <= pace_ff;
					pace_ff <= pace_ff + 2'h1;
				end else
					dly_ff <= dly_ff - 2'h1;
			end
		end
	end
endmodule

// ### testbench/tb.sv
`timescale 1ns/1ps
`include "gdma_map.vh"
module tb;
	reg         ref_clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	reg  [11:0] paddr = 12'h000;
	reg  [31:0] pwdata = 32'h0, rd;
	reg         cycle_request = 1'b0, single_cycle = 1'b1, fhi = 1'b0, flo = 1'b0, err;
	reg  [15:0] din = 16'h0, w0, w1;
	reg  [3:0]  pstrb = 4'hf;
	reg         ba_en = 1'b1, bsel = 1'b0, att = 1'b0;
	reg  [21:0] a;
	reg  [37:0] e;
	reg  [37:0] expq [$];
	wire [31:0] prdata;
	wire        pready, pslverr, busy_n, ready, irq, mst_req, mst_ack;
	wire [21:0] mst_addr;
	wire [1:0]  mst_type;
	wire [15:0] mst_wdata, mst_rdata, dout;
	integer     mismatches = 0, checks_done = 0, seed = 42818, n, k;
	always #12.5 ref_clk = ~ref_clk;
	gdma_core dut_u (.ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.cycle_request(cycle_request), .single_cycle(single_cycle), .wc_inc_enable(1'b1), .ba_inc_enable(ba_en),
		.function_line_high(fhi), .function_line_low(flo), .byte_select_bit(bsel), .attention_line(att),
		.user_in_data(din), .user_out_data(dout), .busy_n(busy_n), .ready(ready), .user_function(), .irq(irq),
		.mst_req(mst_req), .mst_addr(mst_addr), .mst_type(mst_type), .mst_wdata(mst_wdata), .mst_ack(mst_ack),
		.mst_rdata(mst_rdata), .mst_hold());
	gdma_mem_model mem_u (.ref_clk(ref_clk), .resetn(resetn), .mst_req(mst_req), .mst_addr(mst_addr),
		.mst_type(mst_type), .mst_wdata(mst_wdata), .mst_ack(mst_ack), .mst_rdata(mst_rdata));
	// ---------------------------
	// tasks
	// ---------------------------
	function [11:0] ad(input [2:0] i);
		ad = {7'h00, i, 2'h0};
	endfunction
	task give_verdict;
		begin
			$display("checks %0d mismatches %0d", checks_done, mismatches);
			if (mismatches == 0 && checks_done > 0)
				$display("Regression OK");
			else
				$display("Regression broken");
			$finish;
		end
	endtask
	task chk(input [37:0] got, input [37:0] exp);
		begin
			checks_done = checks_done + 1;
			if (got !== exp) begin
				mismatches = mismatches + 1;
				$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task tmo;
		if (n >= 200) begin
			mismatches = mismatches + 1;
			give_verdict;
		end
	endtask
	task apb(input w, input [11:0] ad_i, input [31:0] d);
		begin
			@(posedge ref_clk);
			psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= ad_i; pwdata <= d;
			@(posedge ref_clk);
			penable <= 1'b1;
			n = 0;
			@(posedge ref_clk);
			while (pready !== 1'b1 && n < 200) begin @(posedge ref_clk); n = n + 1; end
			tmo;
			rd = prdata; err = pslverr;
			psel <= 1'b0; penable <= 1'b0;
		end
	endtask
	task ureq(input [15:0] d);
		begin
			@(posedge ref_clk);
			din <= d; cycle_request <= 1'b1;
			n = 0;
			@(posedge ref_clk);
			while (busy_n !== 1'b0 && n < 200) begin @(posedge ref_clk); n = n + 1; end
			tmo;
			cycle_request <= 1'b0;
			// wait for the word to finish, or the burst to end
			while (busy_n !== 1'b1 && n < 200) begin @(posedge ref_clk); n = n + 1; end
			while (!single_cycle && ready !== 1'b1 && n < 200) begin @(posedge ref_clk); n = n + 1; end
			tmo;
		end
	endtask
	// memory writes seen on the host bus, oldest note first
	always @(posedge ref_clk)
		if (mst_req === 1'b1 && mst_ack === 1'b1 && mst_type[1] === 1'b1) begin
			e = expq.size() ? expq.pop_front() : 38'h0;
			chk({mst_addr, mst_wdata}, e);
		end
	// ---------------------------
	// main sequence
	// ---------------------------
	initial begin
		repeat (10) @(posedge ref_clk);
		resetn <= 1'b1;
		apb(0, ad(`GDMA_IDX_CTRL), 0); chk(rd, `GDMA_CTRL_RST);
		apb(0, 12'h014, 0); chk(err, 1'b1);
		$display("test reset done");
		fhi <= 1'b1;
		apb(1, ad(`GDMA_IDX_WCNT), 32'h0000fffd);
		apb(1, ad(`GDMA_IDX_ADDR), 32'h00000100);
		apb(1, ad(`GDMA_IDX_CTRL), 32'h00000000);
		a = 22'h000100;
		for (k = 0; k < 3; k = k + 1) begin
			rd = $random(seed);
			if (k == 0) w0 = rd[15:0];
			if (k == 1) w1 = rd[15:0];
			expq.push_back({a, rd[15:0]}); a = a + 22'h2;
			ureq(rd[15:0]); chk(ready, k == 2);
		end
		apb(0, ad(`GDMA_IDX_WCNT), 0); chk(rd, 32'h0);
		pstrb <= 4'h1;
		apb(1, ad(`GDMA_IDX_WCNT), 32'h00001234);
		pstrb <= 4'hf;
		apb(0, ad(`GDMA_IDX_WCNT), 0); chk(rd, 32'h0);
		$display("test single write done");
		fhi <= 1'b0;
		apb(1, ad(`GDMA_IDX_WCNT), 32'h0000ffff);
		apb(1, ad(`GDMA_IDX_ADDR), 32'h00000100);
		apb(1, ad(`GDMA_IDX_CTRL), 32'h00000000);
		ureq(16'h0); chk(dout, w0);
		$display("test read done");
		flo <= 1'b1; ba_en <= 1'b0; att <= 1'b1;
		apb(1, ad(`GDMA_IDX_WCNT), 32'h0000ffff);
		apb(1, ad(`GDMA_IDX_ADDR), 32'h00000102);
		apb(1, ad(`GDMA_IDX_CTRL), 32'h00000000);
		ureq(16'h0); chk(dout, w1);
		apb(0, ad(`GDMA_IDX_ADDR), 0); chk(rd, 32'h00000102);
		apb(0, ad(`GDMA_IDX_CTRL), 0); chk(rd, 32'h00002080);
		flo <= 1'b0; ba_en <= 1'b1; att <= 1'b0;
		$display("test rmw done");
		single_cycle <= 1'b0; fhi <= 1'b1;
		rd = $random(seed);
		apb(1, ad(`GDMA_IDX_WCNT), 32'h0000fffc);
		apb(1, ad(`GDMA_IDX_ADDR), 32'h00000200);
		apb(1, ad(`GDMA_IDX_CTRL), 32'h00000040);
		a = 22'h000200;
		for (k = 0; k < 4; k = k + 1) begin expq.push_back({a, rd[15:0]}); a = a + 22'h2; end
		ureq(rd[15:0]); chk(ready, 1'b1);
		chk(irq, 1'b1);
		chk(expq.size(), 0);
		apb(1, ad(`GDMA_IDX_CTRL), 32'h00000080);
		@(posedge ref_clk); chk(irq, 1'b0);
		$display("test burst done");
		single_cycle <= 1'b1; flo <= 1'b1; bsel <= 1'b1;
		rd = $random(seed);
		apb(1, ad(`GDMA_IDX_WCNT), 32'h0000ffff);
		apb(1, ad(`GDMA_IDX_ADDR), 32'h00000300);
		apb(1, ad(`GDMA_IDX_CTRL), 32'h00000000);
		expq.push_back({22'h000301, rd[15:0]});
		ureq(rd[15:0]); chk(expq.size(), 0);
		$display("test byte write done");
		give_verdict;
	end
endmodule
